// >>> mdsu_pkg.sv
/*
 * mdsu_pkg: constants, state and op encodings and carrier structs for the
 * multiply, divide, normalize and shift unit.
 * assumes one special-function-register access per clock, one clock per machine cycle.
 */
package mdsu_pkg;

   // special-function-register addresses
   localparam logic [7:0] ADDR_MD0   = 8'he9;
   localparam logic [7:0] ADDR_MD1   = 8'hea;
   localparam logic [7:0] ADDR_MD2   = 8'heb;
   localparam logic [7:0] ADDR_MD3   = 8'hec;
   localparam logic [7:0] ADDR_MD4   = 8'hed;
   localparam logic [7:0] ADDR_MD5   = 8'hee;
   localparam logic [7:0] ADDR_ARITH_CONTROL = 8'hef;

   // data-register index used internally; none means not a data register
   localparam logic [2:0] IDX_NONE   = 3'h7;

   // arith_control field positions
   localparam int ARC_ERR_BIT = 7;
   localparam int ARC_OVF_BIT = 6;
   localparam int ARC_DIR_BIT = 5;
   localparam int ARC_CNT_MSB = 4;

   // reset values
   localparam logic [7:0] MD_RESET  = 8'h00;
   localparam logic [4:0] CNT_RESET = 5'h00;

   // execution times in machine cycles
   localparam logic [2:0] LAT_MUL   = 3'h4;
   localparam logic [2:0] LAT_DIV16 = 3'h4;
   localparam logic [2:0] LAT_DIV32 = 3'h6;

   // shift speed and normalize limit
   localparam logic [5:0] SH_FIRST_STEP = 6'h04;
   localparam logic [5:0] SH_STEP       = 6'h06;
   localparam logic [4:0] NORM_MAX      = 5'h1f;

   typedef enum logic [1:0] {
      OP_MUL   = 2'h0,
      OP_DIV16 = 2'h1,
      OP_DIV32 = 2'h2,
      OP_SHIFT = 2'h3
   } mdsu_op_t;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_MULDIV = 3'b010,
      ST_SHIFT  = 3'b100
   } mdsu_state_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mdsu_sfr_req_t;

   typedef struct packed {
      logic [31:0] quo;
      logic [15:0] rem;
      logic        ovf;
   } mdsu_md_res_t;

endpackage

// >>> mdsu_muldiv.sv
/*
 * mdsu_muldiv: combinational 16x16 multiply, 32/16 and 16/16 divide.
 * assumes the caller holds the result for the documented latency.
 */
`timescale 1ns/1ps
module mdsu_muldiv import mdsu_pkg::*; (
   input  wire mdsu_op_t     op,
   input  wire logic [31:0]  dividend,
   input  wire logic [15:0]  divisor,
   output mdsu_md_res_t      res
);
   logic [31:0] prod;

   always_comb begin
      prod = dividend[15:0] * divisor;
      res  = '0;
      if (op == OP_MUL) begin
         res.quo = prod;
         res.ovf = (prod[31:16] != 16'h0000);
      end else if (divisor == 16'h0000) begin
         res.quo = 32'hffffffff;
         res.rem = dividend[15:0];
         res.ovf = 1'b1;
      end else begin
         res.quo = dividend / {16'h0000, divisor};
         res.rem = 16'(dividend % {16'h0000, divisor});
      end
   end
endmodule // mdsu_muldiv

// >>> mdsu_shifter.sv
/*
 * mdsu_shifter: one machine cycle of shift or normalize on a 32-bit word.
 * assumes the caller tracks the remaining count and the first-cycle flag.
 */
`timescale 1ns/1ps
module mdsu_shifter import mdsu_pkg::*; (
   input  wire logic [31:0] val,
   input  wire logic [4:0]  remain,
   input  wire logic        dir_right,
   input  wire logic        norm,
   input  wire logic        first,
   output logic      [31:0] val_out,
   output logic      [4:0]  amt
);
   logic [5:0] lz;
   logic [5:0] lim;

   always_comb begin
      lz = 6'd32;
      for (int i = 0; i < 32; i++) begin
         if (val[i]) begin
            lz = 6'(31 - i);
         end
      end
      lim = first ? SH_FIRST_STEP : SH_STEP;
      if ({1'b0, remain} < lim) begin
         lim = {1'b0, remain};
      end
      if (norm && lz < lim) begin
         lim = lz;
      end
      amt = lim[4:0];
      if (dir_right && !norm) begin
         val_out = val >> amt;
      end else begin
         val_out = val << amt;
      end
   end
endmodule // mdsu_shifter

// >>> mdsu_unit.sv
/*
 * mdsu_unit: multiply, divide, normalize and shift coprocessor behind six
 * byte-wide data registers and one control register on the sfr bus.
 * assumes sfr_req carries at most one access per clock, clock is the machine cycle.
 */
`timescale 1ns/1ps
module mdsu_unit import mdsu_pkg::*; (
   input  wire logic          clock,
   input  wire logic          sys_rst,
   input  wire mdsu_sfr_req_t sfr_req,
   output logic [7:0]         sfr_rdata
);

   function automatic logic [2:0] md_index(input logic [7:0] a);
      if (a == ADDR_MD0) begin
         return 3'h0;
      end else if (a == ADDR_MD1) begin
         return 3'h1;
      end else if (a == ADDR_MD2) begin
         return 3'h2;
      end else if (a == ADDR_MD3) begin
         return 3'h3;
      end else if (a == ADDR_MD4) begin
         return 3'h4;
      end else if (a == ADDR_MD5) begin
         return 3'h5;
      end else begin
         return IDX_NONE;
      end
   endfunction

   mdsu_state_t  state_reg,  state_next;
   mdsu_op_t     op_reg,     op_next;
   mdsu_md_res_t pend_reg,   pend_next;
   logic [7:0]   md_reg  [0:5];
   logic [7:0]   md_next [0:5];
   logic         err_reg,    err_next;
   logic         ovf_reg,    ovf_next;
   logic         dir_reg,    dir_next;
   logic [4:0]   cnt_reg,    cnt_next;
   logic         armed_reg,  armed_next;
   logic         wide_reg,   wide_next;
   logic         first4_reg, first4_next;
   logic         seen_reg,   seen_next;
   logic [2:0]   timer_reg,  timer_next;
   logic         norm_reg,   norm_next;
   logic         first_reg,  first_next;
   logic [4:0]   done_reg,   done_next;
   logic [4:0]   remain_reg, remain_next;
   logic [7:0]   rdata_reg,  rdata_next;

   logic [2:0]   wr_idx;
   logic [2:0]   rd_idx;
   logic         wr_arc;
   logic         rd_arc;
   logic         err_set;
   mdsu_op_t     launch_op;
   logic [31:0]  dividend_w;
   logic [15:0]  divisor_w;
   mdsu_md_res_t md_res;
   logic [31:0]  md_word;
   logic [31:0]  sh_val;
   logic [4:0]   sh_amt;

   assign md_word   = {md_reg[3], md_reg[2], md_reg[1], md_reg[0]};
   assign sfr_rdata = rdata_reg;

   mdsu_muldiv u_muldiv (
      .op       (launch_op),
      .dividend (dividend_w),
      .divisor  (divisor_w),
      .res      (md_res)
   );

   mdsu_shifter u_shifter (
      .val       (md_word),
      .remain    (remain_reg),
      .dir_right (dir_reg),
      .norm      (norm_reg),
      .first     (first_reg),
      .val_out   (sh_val),
      .amt       (sh_amt)
   );

   always_comb begin
      state_next  = state_reg;
      op_next     = op_reg;
      pend_next   = pend_reg;
      for (int i = 0; i < 6; i++) begin
         md_next[i] = md_reg[i];
      end
      ovf_next    = ovf_reg;
      dir_next    = dir_reg;
      cnt_next    = cnt_reg;
      armed_next  = armed_reg;
      wide_next   = wide_reg;
      first4_next = first4_reg;
      seen_next   = seen_reg;
      timer_next  = timer_reg;
      norm_next   = norm_reg;
      first_next  = first_reg;
      done_next   = done_reg;
      remain_next = remain_reg;
      rdata_next  = 8'h00;

      wr_idx = sfr_req.wr ? md_index(sfr_req.addr) : IDX_NONE;
      rd_idx = sfr_req.rd ? md_index(sfr_req.addr) : IDX_NONE;
      wr_arc = sfr_req.wr && (sfr_req.addr == ADDR_ARITH_CONTROL);
      rd_arc = sfr_req.rd && (sfr_req.addr == ADDR_ARITH_CONTROL);

      // operation chosen by the write sequence
      if (wide_reg) begin
         launch_op = OP_DIV32;
      end else if (first4_reg) begin
         launch_op = OP_MUL;
      end else begin
         launch_op = OP_DIV16;
      end
      if (launch_op == OP_DIV32) begin
         dividend_w = md_word;
      end else begin
         dividend_w = {16'h0000, md_reg[1], md_reg[0]};
      end
      divisor_w = {sfr_req.wdata, md_reg[4]};

      // error monitor
      err_set = ((wr_idx == 3'h0) && (armed_reg || state_reg == ST_SHIFT))
             || ((state_reg == ST_SHIFT) && (rd_idx <= 3'h3));
      err_next = err_set ? 1'b1 : (rd_arc ? 1'b0 : err_reg);

      // running operation
      case (state_reg)
         ST_MULDIV: begin
            if (timer_reg == 3'h0) begin
               md_next[0] = pend_reg.quo[7:0];
               md_next[1] = pend_reg.quo[15:8];
               md_next[2] = pend_reg.quo[23:16];
               md_next[3] = pend_reg.quo[31:24];
               if (op_reg != OP_MUL) begin
                  md_next[4] = pend_reg.rem[7:0];
                  md_next[5] = pend_reg.rem[15:8];
               end
               ovf_next   = pend_reg.ovf;
               state_next = ST_IDLE;
            end else begin
               timer_next = timer_reg - 3'h1;
            end
         end
         ST_SHIFT: begin
            md_next[0]  = sh_val[7:0];
            md_next[1]  = sh_val[15:8];
            md_next[2]  = sh_val[23:16];
            md_next[3]  = sh_val[31:24];
            done_next   = done_reg + sh_amt;
            remain_next = remain_reg - sh_amt;
            first_next  = 1'b0;
            if ((remain_reg == sh_amt) || (norm_reg && sh_val[31])) begin
               if (norm_reg) begin
                  cnt_next = done_reg + sh_amt;
               end
               state_next = ST_IDLE;
            end
         end
         default: begin
         end
      endcase

      // reads
      if (rd_idx != IDX_NONE) begin
         rdata_next = md_reg[rd_idx];
      end else if (rd_arc) begin
         rdata_next = {err_reg, ovf_reg, dir_reg, cnt_reg};
      end
      if ((rd_idx == 3'h5) && (op_reg == OP_DIV16 || op_reg == OP_DIV32)) begin
         armed_next = 1'b0;
      end
      if ((rd_idx == 3'h3) && (op_reg == OP_MUL || op_reg == OP_SHIFT)) begin
         armed_next = 1'b0;
      end

      // writes
      if (wr_idx != IDX_NONE) begin
         md_next[wr_idx] = sfr_req.wdata;
      end
      if (wr_idx == 3'h0) begin
         armed_next  = 1'b1;
         wide_next   = 1'b0;
         first4_next = 1'b0;
         seen_next   = 1'b0;
         state_next  = ST_IDLE;
      end else if (wr_idx == 3'h5) begin
         op_next    = launch_op;
         pend_next  = md_res;
         state_next = ST_MULDIV;
         if (launch_op == OP_DIV32) begin
            timer_next = LAT_DIV32 - 3'h1;
         end else if (launch_op == OP_MUL) begin
            timer_next = LAT_MUL - 3'h1;
         end else begin
            timer_next = LAT_DIV16 - 3'h1;
         end
      end else if (wr_idx != IDX_NONE) begin
         seen_next = 1'b1;
         if (!seen_reg && wr_idx == 3'h4) begin
            first4_next = 1'b1;
         end
         if (wr_idx == 3'h2 || wr_idx == 3'h3) begin
            wide_next = 1'b1;
         end
      end
      if (wr_arc) begin
         dir_next    = sfr_req.wdata[ARC_DIR_BIT];
         cnt_next    = sfr_req.wdata[ARC_CNT_MSB:0];
         norm_next   = (sfr_req.wdata[ARC_CNT_MSB:0] == 5'h00);
         remain_next = norm_next ? NORM_MAX : sfr_req.wdata[ARC_CNT_MSB:0];
         ovf_next    = norm_next && md_reg[3][7];
         op_next     = OP_SHIFT;
         first_next  = 1'b1;
         done_next   = 5'h00;
         state_next  = ST_SHIFT;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_reg  <= ST_IDLE;
         op_reg     <= OP_MUL;
         pend_reg   <= '0;
         for (int i = 0; i < 6; i++) begin
            md_reg[i] <= MD_RESET;
         end
         err_reg    <= 1'b0;
         ovf_reg    <= 1'b0;
         dir_reg    <= 1'b0;
         cnt_reg    <= CNT_RESET;
         armed_reg  <= 1'b0;
         wide_reg   <= 1'b0;
         first4_reg <= 1'b0;
         seen_reg   <= 1'b0;
         timer_reg  <= 3'h0;
         norm_reg   <= 1'b0;
         first_reg  <= 1'b0;
         done_reg   <= 5'h00;
         remain_reg <= 5'h00;
         rdata_reg  <= 8'h00;
      end else begin
         state_reg  <= state_next;
         op_reg     <= op_next;
         pend_reg   <= pend_next;
         for (int i = 0; i < 6; i++) begin
            md_reg[i] <= md_next[i];
         end
         err_reg    <= err_next;
         ovf_reg    <= ovf_next;
         dir_reg    <= dir_next;
         cnt_reg    <= cnt_next;
         armed_reg  <= armed_next;
         wide_reg   <= wide_next;
         first4_reg <= first4_next;
         seen_reg   <= seen_next;
         timer_reg  <= timer_next;
         norm_reg   <= norm_next;
         first_reg  <= first_next;
         done_reg   <= done_next;
         remain_reg <= remain_next;
         rdata_reg  <= rdata_next;
      end
   end

   property p_md0_rewrite_err;
      @(posedge clock) disable iff (sys_rst)
      (wr_idx == 3'h0 && armed_reg) |=> err_reg;
   endproperty
   a_md0_rewrite_err: assert property (p_md0_rewrite_err) else $error("rewrite not flagged");

   property p_err_read_clear;
      @(posedge clock) disable iff (sys_rst)
      (rd_arc && !err_set) |=> !err_reg;
   endproperty
   a_err_read_clear: assert property (p_err_read_clear) else $error("error flag kept");

   property p_shift_read_err;
      @(posedge clock) disable iff (sys_rst)
      (state_reg == ST_SHIFT && rd_idx <= 3'h3) |=> err_reg;
   endproperty
   a_shift_read_err: assert property (p_shift_read_err) else $error("busy read not flagged");

   property p_norm_bound;
      @(posedge clock) disable iff (sys_rst)
      (wr_arc && sfr_req.wdata[4:0] == 5'h00) ##1 (!sfr_req.wr)[*6] |=> state_reg == ST_IDLE;
   endproperty
   a_norm_bound: assert property (p_norm_bound) else $error("normalize too long");

   property p_first_step;
      @(posedge clock) disable iff (sys_rst)
      (wr_arc && !sfr_req.wdata[5] && sfr_req.wdata[4:0] >= 5'h04) ##1 !sfr_req.wr
         |=> md_word == ($past(md_word, 2) << 4);
   endproperty
   a_first_step: assert property (p_first_step) else $error("first shift step wrong");

   property p_norm_ovf;
      @(posedge clock) disable iff (sys_rst)
      (wr_arc && sfr_req.wdata[4:0] == 5'h00 && md_reg[3][7]) |=> ovf_reg;
   endproperty
   a_norm_ovf: assert property (p_norm_ovf) else $error("normalize overflow missed");

   property p_shift_ovf_clear;
      @(posedge clock) disable iff (sys_rst)
      (wr_arc && sfr_req.wdata[4:0] != 5'h00) |=> !ovf_reg;
   endproperty
   a_shift_ovf_clear: assert property (p_shift_ovf_clear) else $error("overflow not cleared");

   property p_disarm_md3;
      @(posedge clock) disable iff (sys_rst)
      (rd_idx == 3'h3 && op_reg == OP_SHIFT && !sfr_req.wr) |=> !armed_reg;
   endproperty
   a_disarm_md3: assert property (p_disarm_md3) else $error("monitor not released");

   property p_muldiv_latency;
      @(posedge clock) disable iff (sys_rst)
      (wr_idx == 3'h5) |-> ##[1:7] state_reg == ST_IDLE;
   endproperty
   a_muldiv_latency: assert property (p_muldiv_latency) else $error("muldiv too long");

endmodule // mdsu_unit

// >>> mdsu_host.sv
/*
 * mdsu_host: host cpu model that drives the sfr bus of the unit.
 * assumes one access per machine cycle, launched just after the falling edge.
 */
`timescale 1ns/1ps
module mdsu_host import mdsu_pkg::*; (
   input  wire logic       clock,
   output mdsu_sfr_req_t   sfr_req,
   input  wire logic [7:0] sfr_rdata
);
   logic [7:0] q;

   initial sfr_req = '0;

   // one access, held for one edge; read data is taken at the falling edge that ends it
   task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      sfr_req = {w, r, a, d};
      @(negedge clock);
      q = sfr_rdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'h1, 1'h0, a, d);
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      bus(1'h0, 1'h1, a, ~sfr_req.wdata);
      v = q;
   endtask

   // released lines toggle so stale values cannot pass
   task automatic idle(input int n);
      repeat (n) bus(1'h0, 1'h0, ~sfr_req.addr, ~sfr_req.wdata);
   endtask

   task automatic load(input mdsu_op_t op, input logic [31:0] w, input logic [15:0] d);
      wr(ADDR_MD0, w[7:0]);
      case (op)
         OP_MUL: begin
            wr(ADDR_MD4, d[7:0]);
            wr(ADDR_MD1, w[15:8]);
         end
         OP_DIV16: begin
            wr(ADDR_MD1, w[15:8]);
            wr(ADDR_MD4, d[7:0]);
         end
         default: begin
            wr(ADDR_MD1, w[15:8]);
            wr(ADDR_MD2, w[23:16]);
            wr(ADDR_MD3, w[31:24]);
         end
      endcase
      if (op == OP_SHIFT) wr(ADDR_ARITH_CONTROL, d[7:0]);
      else begin
         if (op == OP_DIV32) wr(ADDR_MD4, d[7:0]);
         wr(ADDR_MD5, d[15:8]);
      end
   endtask

   // read-out opens with byte 0, ends with byte 3 or byte 5
   task automatic readout(input mdsu_op_t op, output logic [31:0] w, output logic [15:0] r);
      logic [7:0] v;
      w = '0;
      r = '0;
      for (int i = 0; i < 4; i++) begin
         rd(ADDR_MD0 + 8'(i), v);
         w[8*i +: 8] = v;
      end
      if (op == OP_DIV16 || op == OP_DIV32) begin
         rd(ADDR_MD4, v);
         r[7:0] = v;
         rd(ADDR_MD5, v);
         r[15:8] = v;
      end
   endtask
endmodule // mdsu_host

// >>> tb_mul_div_shift_unit_sequencer.sv
/*
 * tb_mul_div_shift_unit_sequencer: self-checking bench, random and corner operations.
 * assumes mdsu_pkg, mdsu_unit and the mdsu_host model are compiled first.
 */
`timescale 1ns/1ps
module tb_mul_div_shift_unit_sequencer import mdsu_pkg::*;;
   logic          clock = 1'h0;
   logic          sys_rst = 1'h1;
   mdsu_sfr_req_t sfr_req;
   logic [7:0]    sfr_rdata;
   int            failures = 0;
   int            n_compared = 0;
   int            cycles = 0;
   int            seed = 24;
   logic [7:0]    c;

   always #20 clock = ~clock;

   mdsu_unit dut (
      .clock     (clock),
      .sys_rst   (sys_rst),
      .sfr_req   (sfr_req),
      .sfr_rdata (sfr_rdata)
   );

   mdsu_host host (
      .clock     (clock),
      .sfr_req   (sfr_req),
      .sfr_rdata (sfr_rdata)
   );

   task automatic print_verdict();
      if (failures == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      chk32({24'h000000, got}, {24'h000000, exp});
   endtask

   // packs {ovf, remainder, multiplier or control low bits, word}
   function automatic logic [48:0] exp_res(input mdsu_op_t op, input logic [31:0] w,
                                           input logic [15:0] d);
      logic [31:0] p;
      int          n;
      p = w[15:0] * d;
      n = 0;
      case (op)
         OP_MUL: return {p > 32'h0000ffff, d, p};
         OP_DIV16: return {1'h0, w[15:0] % d, 16'h0000, w[15:0] / d};
         OP_DIV32: begin
            if (d == 16'h0000) return {1'h1, w[15:0], 32'hffffffff};
            return {1'h0, 16'(w % d), w / d};
         end
         default: begin
            if (d[4:0] != 5'h00)
               return {11'h000, d[5], d[4:0], (d[5] ? w >> d[4:0] : w << d[4:0])};
            while (n < 31 && !w[31 - n]) n++;
            return {w[31], 10'h000, d[5], 5'(n), w << n};
         end
      endcase
   endfunction

   task automatic run(input mdsu_op_t op, input logic [31:0] w, input logic [15:0] d,
                      input logic err, input logic early);
      logic [31:0] rw;
      logic [15:0] rm;
      logic [48:0] e;
      e = exp_res(op, w, d);
      host.load(op, w, d);
      if (early) host.rd(ADDR_MD0, c);
      host.idle(6 + (op == OP_SHIFT ? 0 : ($random(seed) & 7)));
      host.readout(op, rw, rm);
      host.rd(ADDR_ARITH_CONTROL, c);
      chk32(rw, e[31:0]);
      if (op == OP_SHIFT) chk8(c, {err, e[48], e[37:32]});
      else chk8({c[7:6], 6'h00}, {err, e[48], 6'h00});
      if (op == OP_DIV16 || op == OP_DIV32) chk32({16'h0000, rm}, {16'h0000, e[47:32]});
   endtask

   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         failures++;
         print_verdict();
      end
   end

   initial begin
      logic [31:0] w;
      logic [15:0] d;
      repeat (3) @(negedge clock);
      sys_rst = 1'h0;
      host.rd(ADDR_ARITH_CONTROL, c);
      chk8(c, 8'h00);
      host.rd(8'h10, c);
      chk8(c, 8'h00);
      run(OP_MUL, 32'h0000ffff, 16'hffff, 1'h0, 1'h0);
      run(OP_MUL, 32'h00000001, 16'hffff, 1'h0, 1'h0);
      run(OP_DIV32, 32'h12345678, 16'h0000, 1'h0, 1'h0);
      run(OP_DIV16, 32'h0000ffff, 16'h0001, 1'h0, 1'h0);
      run(OP_SHIFT, 32'h00000000, 16'h00c0, 1'h0, 1'h0);
      run(OP_SHIFT, 32'h00000001, 16'h0000, 1'h0, 1'h0);
      run(OP_SHIFT, 32'h80000001, 16'h0000, 1'h0, 1'h0);
      run(OP_SHIFT, 32'hffffffff, 16'h003f, 1'h0, 1'h0);
      run(OP_SHIFT, 32'hffffffff, 16'h001f, 1'h0, 1'h0);
      run(OP_SHIFT, 32'h80000000, 16'h0021, 1'h0, 1'h0);
      host.load(OP_MUL, 32'h00001234, 16'h5678);
      host.idle(8);
      host.rd(ADDR_MD0, c);
      run(OP_DIV32, 32'hdeadbeef, 16'h0123, 1'h1, 1'h0);
      host.rd(ADDR_ARITH_CONTROL, c);
      chk8({c[7], 7'h00}, 8'h00);
      host.load(OP_SHIFT, 32'h00000001, 16'h001f);
      run(OP_MUL, 32'h00001234, 16'h0010, 1'h1, 1'h0);
      run(OP_SHIFT, 32'h0000f00d, 16'h001f, 1'h1, 1'h1);
      for (int i = 0; i < 40; i++) begin
         w = $random(seed);
         d = $random(seed);
         if (i % 4 == 1 && d == 16'h0000) d = 16'h0001;
         run(mdsu_op_t'(i % 4), w, d, 1'h0, 1'h0);
      end
      print_verdict();
   end
endmodule // tb_mul_div_shift_unit_sequencer
